// >>> sdio_top.sv
`timescale 1ns/1ps
module sdio_top #(
    parameter int CYC_PER_MS = sdio_pkg::CYC_PER_MS
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // Attribute access port
    input  wire logic        acc_req,
    input  wire logic        acc_wr,
    input  wire logic        acc_get_all,
    input  wire logic [7:0]  acc_class,
    input  wire logic [7:0]  acc_inst,
    input  wire logic [7:0]  acc_attr,
    input  wire logic [4:0]  acc_index,
    input  wire logic [31:0] acc_wdata,
    output logic             acc_ack,
    output logic             acc_err,
    output logic      [31:0] acc_rdata,
    // Device condition
    input  wire logic        owner_present,
    input  wire logic [3:0]  ext_status,
    input  wire logic        self_testing,
    input  wire logic        minor_rec_fault,
    input  wire logic        minor_unrec_fault,
    input  wire logic        major_rec_fault,
    input  wire logic        major_unrec_fault,
    // Connection condition
    input  wire logic        comm_fault,
    input  wire logic        comm_idle,
    // Field points
    input  wire logic [3:0]  field_in,
    output logic      [1:0]  relay_out
);
    localparam int NI = sdio_pkg::NUM_INPUTS;
    localparam int NR = sdio_pkg::NUM_RELAYS;

    // ******************************************************
    // Settings
    // ******************************************************
    logic [31:0] unit_serial_number_r;
    logic [31:0] input_filter_time_r [NI];
    logic [1:0]  relay_points_assembly_r;
    logic [1:0]  relay_fault_behaviour_r;
    logic [1:0]  relay_fault_value_r;
    logic [1:0]  relay_idle_behaviour_r;
    logic [1:0]  relay_idle_value_r;
    logic [3:0]  filt_r;
    logic [1:0]  relay_out_r;

    // ******************************************************
    // Request decode
    // ******************************************************
    function automatic logic is_at(input logic [7:0] c, input logic [7:0] i,
                                   input logic [7:0] a);
        is_at = acc_class == c && acc_inst == i && acc_attr == a;
    endfunction : is_at

    function automatic logic pt_inst(input logic [7:0] n);
        pt_inst = acc_inst >= 8'h01 && acc_inst <= n;
    endfunction : pt_inst

    logic       in_pt;
    logic       rl_pt;
    logic [1:0] in_idx;
    logic       rl_idx;
    logic       wr_serial;
    logic       wr_name;
    logic       wr_relay_asm;
    logic       wr_relay_pt;
    logic       wr_filter;
    logic       wr_rl_attr;
    logic       wr_hit;
    logic       rd_hit;

    always_comb begin
        in_pt  = acc_class == sdio_pkg::CLS_INPUT
                 && pt_inst(8'(sdio_pkg::NUM_INPUTS));
        rl_pt  = acc_class == sdio_pkg::CLS_RELAY
                 && pt_inst(8'(sdio_pkg::NUM_RELAYS));
        in_idx = 2'(acc_inst - 8'h01);
        rl_idx = acc_inst[1];
        wr_serial    = is_at(sdio_pkg::CLS_IDENT, sdio_pkg::INST_IDENT,
                             sdio_pkg::ATTR_SERIAL);
        wr_name      = is_at(sdio_pkg::CLS_IDENT, sdio_pkg::INST_IDENT,
                             sdio_pkg::ATTR_USER_NAME);
        wr_relay_asm = is_at(sdio_pkg::CLS_ASSEMBLY,
                             sdio_pkg::INST_RELAY_ASM,
                             sdio_pkg::ATTR_ASM_DATA);
        wr_relay_pt  = rl_pt && acc_attr == sdio_pkg::ATTR_POINT;
        wr_filter    = in_pt && acc_attr == sdio_pkg::ATTR_FILTER;
        wr_rl_attr   = rl_pt && (acc_attr == sdio_pkg::ATTR_FLT_BEH
                       || acc_attr == sdio_pkg::ATTR_FLT_VAL
                       || acc_attr == sdio_pkg::ATTR_IDLE_BEH
                       || acc_attr == sdio_pkg::ATTR_IDLE_VAL);
        wr_hit = wr_serial || wr_name || wr_relay_asm || wr_relay_pt
                 || wr_filter || wr_rl_attr;
        rd_hit = wr_hit
            || is_at(sdio_pkg::CLS_IDENT, sdio_pkg::INST_IDENT,
                     sdio_pkg::ATTR_STATUS)
            || is_at(sdio_pkg::CLS_IDENT, sdio_pkg::INST_IDENT,
                     sdio_pkg::ATTR_STATE)
            || is_at(sdio_pkg::CLS_ASSEMBLY, sdio_pkg::INST_IN_ASM,
                     sdio_pkg::ATTR_ASM_DATA)
            || is_at(sdio_pkg::CLS_ASSEMBLY, sdio_pkg::INST_COMB_ASM,
                     sdio_pkg::ATTR_ASM_DATA)
            || (in_pt && acc_attr == sdio_pkg::ATTR_POINT);
    end

    // Take a request once; answer two edges later so the name
    // store's registered read data is ready in time.
    logic busy_r;
    logic start;
    logic do_wr;
    assign start = acc_req && !busy_r && !acc_ack;
    assign do_wr = start && acc_wr && wr_hit;

    // ******************************************************
    // Writable attributes
    // ******************************************************
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            unit_serial_number_r <= sdio_pkg::SERIAL_RST;
        end else if (do_wr && wr_serial) begin
            unit_serial_number_r <= acc_wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            for (int k = 0; k < NI; k++) begin
                input_filter_time_r[k] <= sdio_pkg::FILTER_RST;
            end
        end else if (do_wr && wr_filter) begin
            input_filter_time_r[in_idx] <= acc_wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            relay_points_assembly_r <= 2'h0;
        end else if (do_wr && wr_relay_asm) begin
            relay_points_assembly_r <= acc_wdata[1:0];
        end else if (do_wr && wr_relay_pt) begin
            relay_points_assembly_r[rl_idx] <= acc_wdata[0];
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            relay_fault_behaviour_r <= sdio_pkg::FLT_BEH_RST;
            relay_fault_value_r     <= sdio_pkg::FLT_VAL_RST;
            relay_idle_behaviour_r  <= sdio_pkg::IDLE_BEH_RST;
            relay_idle_value_r      <= sdio_pkg::IDLE_VAL_RST;
        end else if (do_wr && wr_rl_attr) begin
            unique case (acc_attr)
                sdio_pkg::ATTR_FLT_BEH:
                    relay_fault_behaviour_r[rl_idx] <= acc_wdata[0];
                sdio_pkg::ATTR_FLT_VAL:
                    relay_fault_value_r[rl_idx] <= acc_wdata[0];
                sdio_pkg::ATTR_IDLE_BEH:
                    relay_idle_behaviour_r[rl_idx] <= acc_wdata[0];
                default:
                    relay_idle_value_r[rl_idx] <= acc_wdata[0];
            endcase
        end
    end

    // ******************************************************
    // User name store
    // ******************************************************
    logic [7:0] name_rd;

    sdio_name_mem u_name (
        .sys_clk (sys_clk),
        .wr_en   (do_wr && wr_name),
        .wr_addr (acc_index),
        .wr_data (acc_wdata[7:0]),
        .rd_addr (acc_index),
        .rd_data (name_rd)
    );

    // ******************************************************
    // Input debounce
    // ******************************************************
    // Per-input cycle and ms counters so each input gets the full
    // time; a shared ms tick would shorten it by up to one ms.
    logic [31:0] sub_r [NI];
    logic [31:0] ms_r  [NI];

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            filt_r <= 4'h0;
            for (int k = 0; k < NI; k++) begin
                sub_r[k] <= 32'h0;
                ms_r[k]  <= 32'h0;
            end
        end else begin
            for (int k = 0; k < NI; k++) begin
                if (field_in[k] == filt_r[k]) begin
                    sub_r[k] <= 32'h0;
                    ms_r[k]  <= 32'h0;
                end else if (ms_r[k] >= input_filter_time_r[k]) begin
                    filt_r[k] <= field_in[k];
                    sub_r[k]  <= 32'h0;
                    ms_r[k]   <= 32'h0;
                end else if (sub_r[k] == 32'(CYC_PER_MS - 1)) begin
                    sub_r[k] <= 32'h0;
                    ms_r[k]  <= ms_r[k] + 32'h1;
                end else begin
                    sub_r[k] <= sub_r[k] + 32'h1;
                end
            end
        end
    end

    // ******************************************************
    // Relay drive
    // ******************************************************
    // Fault outranks idle; "no change" holds the driven level.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            relay_out_r <= 2'h0;
        end else begin
            for (int k = 0; k < NR; k++) begin
                if (comm_fault) begin
                    if (!relay_fault_behaviour_r[k]) begin
                        relay_out_r[k] <= relay_fault_value_r[k];
                    end
                end else if (comm_idle) begin
                    if (!relay_idle_behaviour_r[k]) begin
                        relay_out_r[k] <= relay_idle_value_r[k];
                    end
                end else begin
                    relay_out_r[k] <= relay_points_assembly_r[k];
                end
            end
        end
    end
    // Relay values 0 off, 1 on, passed through unchanged
    assign relay_out = relay_out_r;

    // ******************************************************
    // Identity status and state
    // ******************************************************
    logic        cfg_changed;
    logic [15:0] status_word;
    logic [7:0]  state_code;
    logic [7:0]  rl_cfg;
    logic [31:0] rd_val;

    always_comb begin
        // Only application settings count; identity data does not
        cfg_changed = relay_fault_behaviour_r != sdio_pkg::FLT_BEH_RST
            || relay_fault_value_r != sdio_pkg::FLT_VAL_RST
            || relay_idle_behaviour_r != sdio_pkg::IDLE_BEH_RST
            || relay_idle_value_r != sdio_pkg::IDLE_VAL_RST;
        for (int k = 0; k < NI; k++) begin
            cfg_changed |= input_filter_time_r[k] != sdio_pkg::FILTER_RST;
        end
        status_word = {5'h00, major_rec_fault, minor_unrec_fault,
                       minor_rec_fault, ext_status, 1'b0,
                       cfg_changed, 1'b0, owner_present};
        state_code = acc_get_all ? sdio_pkg::GET_ALL_STATE
            : major_unrec_fault ? sdio_pkg::SDIO_MAJOR_UNREC
            : major_rec_fault ? sdio_pkg::SDIO_MAJOR_REC
            : self_testing ? sdio_pkg::SDIO_SELF_TEST
            : owner_present ? sdio_pkg::SDIO_OPERATIONAL
            : sdio_pkg::SDIO_STANDBY;
        // Relay settings laid out by attribute, then by relay
        rl_cfg = {relay_idle_value_r, relay_idle_behaviour_r,
                  relay_fault_value_r, relay_fault_behaviour_r};
        rd_val = wr_serial ? unit_serial_number_r
            : wr_name ? {24'h0, name_rd}
            : wr_relay_asm ? {30'h0, relay_points_assembly_r}
            : wr_relay_pt ? {31'h0, relay_points_assembly_r[rl_idx]}
            : wr_filter ? input_filter_time_r[in_idx]
            : wr_rl_attr ? {31'h0, rl_cfg[{acc_attr[1:0] - 2'h1, rl_idx}]}
            : acc_class == sdio_pkg::CLS_IDENT
                ? (acc_attr == sdio_pkg::ATTR_STATE ? {24'h0, state_code}
                                                    : {16'h0, status_word})
            : acc_class != sdio_pkg::CLS_ASSEMBLY ? {31'h0, filt_r[in_idx]}
            : acc_inst == sdio_pkg::INST_IN_ASM ? {28'h0, filt_r}
            : {24'h0, filt_r, relay_out_r, 2'h0};
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            busy_r    <= 1'b0;
            acc_ack   <= 1'b0;
            acc_err   <= 1'b0;
            acc_rdata <= 32'h0000_0000;
        end else begin
            busy_r    <= start;
            acc_ack   <= busy_r;
            acc_err   <= acc_wr ? !wr_hit : !rd_hit;
            acc_rdata <= rd_val;
        end
    end
endmodule : sdio_top

// >>> sdio_pkg.sv
package sdio_pkg;
    // ******************************************************
    // Object addressing (class / instance / attribute)
    // ******************************************************
    localparam logic [7:0] CLS_IDENT      = 8'h01;
    localparam logic [7:0] CLS_ASSEMBLY   = 8'h04;
    localparam logic [7:0] CLS_INPUT      = 8'h08;
    localparam logic [7:0] CLS_RELAY      = 8'h09;
    localparam logic [7:0] INST_IDENT     = 8'h01;
    localparam logic [7:0] INST_IN_ASM    = 8'h03;
    localparam logic [7:0] INST_RELAY_ASM = 8'h20;
    localparam logic [7:0] INST_COMB_ASM  = 8'h6b;
    localparam logic [7:0] ATTR_STATUS    = 8'h05;
    localparam logic [7:0] ATTR_SERIAL    = 8'h06;
    localparam logic [7:0] ATTR_STATE     = 8'h08;
    localparam logic [7:0] ATTR_USER_NAME = 8'hb0;
    localparam logic [7:0] ATTR_ASM_DATA  = 8'h03;
    localparam logic [7:0] ATTR_POINT     = 8'h03;
    localparam logic [7:0] ATTR_FILTER    = 8'h65;
    localparam logic [7:0] ATTR_FLT_BEH   = 8'h05;
    localparam logic [7:0] ATTR_FLT_VAL   = 8'h06;
    localparam logic [7:0] ATTR_IDLE_BEH  = 8'h07;
    localparam logic [7:0] ATTR_IDLE_VAL  = 8'h08;

    // ******************************************************
    // Status word fields
    // ******************************************************
    localparam int ST_OWNED      = 0;
    localparam int ST_CONFIGURED = 2;
    localparam int ST_EXT_LO     = 4;
    localparam int ST_MINOR_REC  = 8;
    localparam int ST_MINOR_UNR  = 9;
    localparam int ST_MAJOR_REC  = 10;

    // ******************************************************
    // Assembly bit positions
    // ******************************************************
    localparam int COMB_RELAY_LO = 2;
    localparam int COMB_INPUT_LO = 4;

    // ******************************************************
    // Sizes, reset values, timing
    // ******************************************************
    localparam int NUM_INPUTS = 4;
    localparam int NUM_RELAYS = 2;
    localparam int NAME_BYTES = 32;
    localparam logic [31:0] SERIAL_RST   = 32'h0000_0000;
    localparam logic [31:0] FILTER_RST   = 32'h0000_0000;
    localparam logic [1:0]  FLT_BEH_RST  = 2'h0;
    localparam logic [1:0]  FLT_VAL_RST  = 2'h0;
    localparam logic [1:0]  IDLE_BEH_RST = 2'h0;
    localparam logic [1:0]  IDLE_VAL_RST = 2'h0;
    localparam logic [7:0]  GET_ALL_STATE = 8'hff;
    localparam int CLK_HZ      = 25_000_000;
    localparam int FILTER_UNIT_MS = 1;
    localparam int CYC_PER_MS  = CLK_HZ / 1000 * FILTER_UNIT_MS;

    typedef enum logic [7:0] {
        SDIO_NONEXISTENT = 8'h00,
        SDIO_SELF_TEST   = 8'h01,
        SDIO_STANDBY     = 8'h02,
        SDIO_OPERATIONAL = 8'h03,
        SDIO_MAJOR_REC   = 8'h04,
        SDIO_MAJOR_UNREC = 8'h05
    } sdio_state_t;
endpackage : sdio_pkg

// >>> sdio_name_mem.sv
`timescale 1ns/1ps
module sdio_name_mem (
    // Clock
    input  wire logic       sys_clk,
    // Write port
    input  wire logic       wr_en,
    input  wire logic [4:0] wr_addr,
    input  wire logic [7:0] wr_data,
    // Read port, data registered
    input  wire logic [4:0] rd_addr,
    output logic      [7:0] rd_data
);
    logic [7:0] mem [0:sdio_pkg::NAME_BYTES-1];

    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule : sdio_name_mem

// >>> sdio_scan_model.sv
`timescale 1ns/1ps
// ********************************************
// Scanner side of the attribute access port
// ********************************************
module sdio_scan_model (
    // Clock
    input  wire logic        sys_clk,
    // Request
    output logic             acc_req,
    output logic             acc_wr,
    output logic             acc_get_all,
    output logic      [7:0]  acc_class,
    output logic      [7:0]  acc_inst,
    output logic      [7:0]  acc_attr,
    output logic      [4:0]  acc_index,
    output logic      [31:0] acc_wdata,
    // Answer
    input  wire logic        acc_ack,
    input  wire logic        acc_err,
    input  wire logic [31:0] acc_rdata
);
    initial begin
        {acc_req, acc_wr, acc_get_all} = 3'h0;
        {acc_class, acc_inst, acc_attr} = 24'h0;
        acc_index = 5'h00;
        acc_wdata = 32'h0000_0000;
    end

    // Relay assembly writes carry bit 0 and bit 1 as relays 1 and 2
    task xfer(input logic w, ga, input logic [7:0] c, i, a,
              input logic [4:0] x, input logic [31:0] d,
              output logic [31:0] q, output logic e);
        int n;
        n = 0;
        acc_req <= 1'b1;
        acc_wr <= w;
        acc_get_all <= ga;
        {acc_class, acc_inst, acc_attr} <= {c, i, a};
        acc_index <= x;
        acc_wdata <= d;
        @(posedge sys_clk);
        while (acc_ack !== 1'b1 && n < 50) begin
            @(posedge sys_clk);
            n++;
        end
        // A missing answer reads as unknown so the bench flags it
        q = (acc_ack === 1'b1) ? acc_rdata : 'x;
        e = (acc_ack === 1'b1) ? acc_err : 1'bx;
        acc_req <= 1'b0;
        // Released data line must not look like held data
        acc_wdata <= ~d;
        @(posedge sys_clk);
    endtask : xfer
endmodule : sdio_scan_model

// >>> sdio_chk.sv
`timescale 1ns/1ps
// ********************************************
// Port checks of the attribute block
// ********************************************
module sdio_chk (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        resetn,
    // Access answers
    input wire logic        acc_ack,
    input wire logic        acc_wr,
    input wire logic        acc_get_all,
    input wire logic [7:0]  acc_class,
    input wire logic [7:0]  acc_inst,
    input wire logic [7:0]  acc_attr,
    input wire logic [31:0] acc_rdata,
    // Condition and points
    input wire logic        owner_present,
    input wire logic [3:0]  ext_status,
    input wire logic        minor_rec_fault,
    input wire logic        minor_unrec_fault,
    input wire logic        major_rec_fault,
    input wire logic        major_unrec_fault,
    input wire logic        comm_fault,
    input wire logic        comm_idle,
    input wire logic [3:0]  field_in,
    input wire logic [1:0]  relay_out
);
    logic rd_ok, id_rd, st_rd, sc_rd, as_rd;
    assign rd_ok = acc_ack && !acc_wr;
    assign id_rd = rd_ok && acc_class == sdio_pkg::CLS_IDENT;
    assign st_rd = id_rd && acc_attr == sdio_pkg::ATTR_STATUS;
    assign sc_rd = id_rd && acc_attr == sdio_pkg::ATTR_STATE;
    assign as_rd = rd_ok && acc_class == sdio_pkg::CLS_ASSEMBLY;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    property p_owned; st_rd |-> acc_rdata[0] == owner_present; endproperty
    a_owned: assert property (p_owned) else $error("owned bit");
    property p_ext; st_rd |-> acc_rdata[7:4] == ext_status; endproperty
    a_ext: assert property (p_ext) else $error("ext status");
    property p_flt;
        st_rd |-> acc_rdata[10:8] ==
            {major_rec_fault, minor_unrec_fault, minor_rec_fault};
    endproperty
    a_flt: assert property (p_flt) else $error("fault bits");
    property p_all; sc_rd && acc_get_all |-> acc_rdata[7:0] == 8'hff;
    endproperty
    a_all: assert property (p_all) else $error("get all");
    property p_unrec;
        sc_rd && !acc_get_all && major_unrec_fault |->
            acc_rdata[7:0] == 8'h05;
    endproperty
    a_unrec: assert property (p_unrec) else $error("state");
    property p_rly;
        as_rd && acc_inst == sdio_pkg::INST_RELAY_ASM && !comm_fault
            && !comm_idle |-> acc_rdata[1:0] == relay_out;
    endproperty
    a_rly: assert property (p_rly) else $error("relay asm");
    property p_comb;
        as_rd && acc_inst == sdio_pkg::INST_COMB_ASM |->
            acc_rdata[3:2] == relay_out;
    endproperty
    a_comb: assert property (p_comb) else $error("comb asm");
    // Holds only while filters stay under eight cycles
    property p_in;
        $stable(field_in)[*8] ##1
            (as_rd && acc_inst == sdio_pkg::INST_IN_ASM) |->
            acc_rdata[3:0] == field_in;
    endproperty
    a_in: assert property (p_in) else $error("input asm");
    c_st: cover property (st_rd);
    c_all: cover property (sc_rd && acc_get_all);
    c_flt: cover property ($rose(comm_fault));
endmodule : sdio_chk

bind sdio_top sdio_chk chk_u (.*);

// >>> sdio_top_tb.sv
`timescale 1ns/1ps
module sdio_top_tb;
    logic sys_clk, resetn, acc_req, acc_wr, acc_get_all, acc_ack, acc_err;
    logic [7:0] acc_class, acc_inst, acc_attr;
    logic [4:0] acc_index;
    logic [31:0] acc_wdata, acc_rdata, q;
    logic owner_present, self_testing, minor_rec_fault, minor_unrec_fault;
    logic major_rec_fault, major_unrec_fault, comm_fault, comm_idle, e;
    logic [3:0] ext_status, field_in;
    logic [1:0] relay_out;
    int n_mismatch, tests_run, cyc;

    sdio_top #(.CYC_PER_MS(4)) dut_u (.*);
    sdio_scan_model scan_u (.*);

    always #20 sys_clk = ~sys_clk;

    task end_sim;
        if (n_mismatch == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_sim

    task chk(input string nm, input logic [31:0] x, g);
        tests_run++;
        if (g !== x) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, x, g);
        end
    endtask : chk

    task rd(input logic [7:0] c, i, a, input logic [4:0] x, input logic ga);
        scan_u.xfer(1'b0, ga, c, i, a, x, 32'h0, q, e);
    endtask : rd

    task wr(input logic [7:0] c, i, a, input logic [4:0] x,
            input logic [31:0] d);
        scan_u.xfer(1'b1, 1'b0, c, i, a, x, d, q, e);
    endtask : wr

    // Cut a hung run short
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            end_sim();
        end
    end

    initial begin
        {sys_clk, resetn, owner_present, self_testing} = 4'h0;
        {minor_rec_fault, minor_unrec_fault, major_rec_fault} = 3'h0;
        {major_unrec_fault, comm_fault, comm_idle} = 3'h0;
        {ext_status, field_in} = 8'h00;
        {n_mismatch, tests_run, cyc} = 0;
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        rd(sdio_pkg::CLS_IDENT, 8'h01, sdio_pkg::ATTR_SERIAL, 5'h0, 1'b0);
        chk("serial_rst", sdio_pkg::SERIAL_RST, q);
        rd(sdio_pkg::CLS_INPUT, 8'h01, sdio_pkg::ATTR_FILTER, 5'h0, 1'b0);
        chk("filter_rst", sdio_pkg::FILTER_RST, q);
        owner_present <= 1'b1;
        ext_status <= 4'ha;
        {major_rec_fault, minor_rec_fault} <= 2'h3;
        rd(sdio_pkg::CLS_IDENT, 8'h01, sdio_pkg::ATTR_STATUS, 5'h0, 1'b0);
        chk("status", 32'h05a1, {16'h0, q[15:0]});
        major_unrec_fault <= 1'b1;
        rd(sdio_pkg::CLS_IDENT, 8'h01, sdio_pkg::ATTR_STATE, 5'h0, 1'b0);
        chk("state", 32'h05, {24'h0, q[7:0]});
        rd(sdio_pkg::CLS_IDENT, 8'h01, sdio_pkg::ATTR_STATE, 5'h0, 1'b1);
        chk("get_all", 32'hff, {24'h0, q[7:0]});
        wr(sdio_pkg::CLS_IDENT, 8'h01, sdio_pkg::ATTR_SERIAL, 5'h0,
           32'hc0ff_ee12);
        rd(sdio_pkg::CLS_IDENT, 8'h01, sdio_pkg::ATTR_SERIAL, 5'h0, 1'b0);
        chk("serial", 32'hc0ff_ee12, q);
        wr(sdio_pkg::CLS_IDENT, 8'h01, sdio_pkg::ATTR_USER_NAME, 5'h1f,
           32'h5a);
        rd(sdio_pkg::CLS_IDENT, 8'h01, sdio_pkg::ATTR_USER_NAME, 5'h1f,
           1'b0);
        chk("name", 32'h5a, {24'h0, q[7:0]});
        wr(sdio_pkg::CLS_ASSEMBLY, sdio_pkg::INST_RELAY_ASM, 8'h03, 5'h0,
           32'h2);
        chk("relay", 32'h2, {30'h0, relay_out});
        rd(sdio_pkg::CLS_ASSEMBLY, sdio_pkg::INST_RELAY_ASM, 8'h03, 5'h0,
           1'b0);
        chk("relay_asm", 32'h2, q);
        field_in <= 4'h5;
        repeat (4) @(posedge sys_clk);
        rd(sdio_pkg::CLS_ASSEMBLY, sdio_pkg::INST_IN_ASM, 8'h03, 5'h0, 1'b0);
        chk("in_asm", 32'h5, {28'h0, q[3:0]});
        rd(sdio_pkg::CLS_ASSEMBLY, sdio_pkg::INST_COMB_ASM, 8'h03, 5'h0,
           1'b0);
        chk("comb_asm", 32'h16, {26'h0, q[7:2]});
        // Relay 1 takes its fault value, relay 2 holds
        wr(sdio_pkg::CLS_RELAY, 8'h01, sdio_pkg::ATTR_FLT_VAL, 5'h0, 32'h1);
        wr(sdio_pkg::CLS_RELAY, 8'h02, sdio_pkg::ATTR_FLT_BEH, 5'h0, 32'h1);
        comm_fault <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk("fault", 32'h3, {30'h0, relay_out});
        comm_fault <= 1'b0;
        wr(sdio_pkg::CLS_ASSEMBLY, sdio_pkg::INST_RELAY_ASM, 8'h03, 5'h0,
           32'h1);
        // Relay 1 holds, relay 2 takes its idle value
        wr(sdio_pkg::CLS_RELAY, 8'h01, sdio_pkg::ATTR_IDLE_BEH, 5'h0, 32'h1);
        wr(sdio_pkg::CLS_RELAY, 8'h02, sdio_pkg::ATTR_IDLE_VAL, 5'h0, 32'h1);
        comm_idle <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk("idle", 32'h3, {30'h0, relay_out});
        comm_idle <= 1'b0;
        rd(sdio_pkg::CLS_IDENT, 8'h01, sdio_pkg::ATTR_STATUS, 5'h0, 1'b0);
        chk("configured", 32'h1, {31'h0, q[2]});
        // Input 1 filtered for 3 ms, input 2 unfiltered
        wr(sdio_pkg::CLS_INPUT, 8'h01, sdio_pkg::ATTR_FILTER, 5'h0, 32'h3);
        field_in <= 4'h6;
        @(posedge sys_clk);
        rd(sdio_pkg::CLS_ASSEMBLY, sdio_pkg::INST_IN_ASM, 8'h03, 5'h0, 1'b0);
        chk("filter_mid", 32'h7, {28'h0, q[3:0]});
        repeat (16) @(posedge sys_clk);
        rd(sdio_pkg::CLS_ASSEMBLY, sdio_pkg::INST_IN_ASM, 8'h03, 5'h0, 1'b0);
        chk("filter_end", 32'h6, {28'h0, q[3:0]});
        rd(8'h77, 8'h01, 8'h01, 5'h0, 1'b0);
        chk("unmapped_err", 32'h1, {31'h0, e});
        end_sim();
    end
endmodule : sdio_top_tb
